// [core/tdh_pkg.sv]
/*
 Constants, types and register map of the transmit and DMA descriptor handler.
 Assumes one clock domain and a plain register port with one-cycle read latency.
*/
package tdh_pkg;
    // ------------------------------------------------------------------
    // Descriptor fields
    // ------------------------------------------------------------------
    localparam int TDH_BIT_TYPE = 63;
    localparam int TDH_BIT_FIRST = 61;
    localparam int TDH_BIT_LAST = 60;
    localparam int TDH_BIT_SWITCH = 46;
    localparam int TDH_BIT_MODE = 45;
    localparam int TDH_LEN_HI = 44;
    localparam int TDH_LEN_LO = 32;
    localparam int TDH_TAG_HI = 59;
    localparam int TDH_TAG_LO = 48;
    localparam int TDH_DST_DISCARD = 62;
    localparam int TDH_DST_LEN_HI = 39;
    localparam int TDH_DST_LEN_LO = 32;
    localparam logic [4:0] TDH_MAX_BUFS = 5'h10;
    localparam logic [13:0] TDH_DMA_ZERO_LEN = 14'h2000;
    localparam logic [13:0] TDH_DST_MIN_LEN = 14'h0040;
    // ------------------------------------------------------------------
    // Indication fields
    // ------------------------------------------------------------------
    localparam int TDH_IND_SINGLE = 61;
    localparam int TDH_IND_PERR_HI = 50;
    localparam int TDH_IND_PERR_LO = 48;
    localparam int TDH_IND_ABORT = 47;
    localparam int TDH_IND_UNDERRUN = 46;
    localparam int TDH_IND_PARITY = 45;
    localparam int TDH_IND_TAG_HI = 11;
    // ------------------------------------------------------------------
    // Port error codes
    // ------------------------------------------------------------------
    localparam logic [2:0] TDH_PERR_NONE = 3'h0;
    localparam logic [2:0] TDH_PERR_FIFO_ABORT = 3'h1;
    localparam logic [2:0] TDH_PERR_FIFO_PARITY = 3'h2;
    localparam logic [2:0] TDH_PERR_IM_LOCAL_ABORT = 3'h4;
    localparam logic [2:0] TDH_PERR_IM_ABORT = 3'h5;
    localparam logic [2:0] TDH_PERR_IM_PARITY = 3'h6;
    localparam logic [2:0] TDH_PERR_IM_LOCAL_PARITY = 3'h7;
    localparam logic [2:0] TDH_PERR_DST_ABORT = 3'h4;
    localparam logic [2:0] TDH_PERR_DST_PARITY = 3'h7;
    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    localparam logic [3:0] TDH_REG_CTRL = 4'h0;
    localparam logic [3:0] TDH_REG_STATUS = 4'h4;
    localparam logic [3:0] TDH_REG_FRAMES = 4'h8;
    localparam logic [3:0] TDH_REG_LAST_IND = 4'hc;
    localparam int TDH_CTRL_ENABLE = 0;
    localparam logic TDH_CTRL_ENABLE_RESET = 1'b0;
    localparam int TDH_PEND_DEPTH = 4;
    localparam logic [2:0] TDH_PEND_FULL = 3'h4;

    typedef enum logic [1:0] {
        TDH_IDLE = 2'b00,
        TDH_FETCH = 2'b01,
        TDH_IND = 2'b10
    } tdh_state_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [13:0] len;
        logic port;
        logic [2:0] fifo_sel;
        logic cmd_fifo;
    } tdh_fetch_t;

    typedef struct packed {
        logic underrun;
        logic parity;
        logic ext_abort;
        logic [2:0] dst_perr;
    } tdh_done_t;

    typedef struct packed {
        logic [31:0] addr;
        logic single;
        logic mode;
        logic dma;
        logic [2:0] perr;
        logic [11:0] tag;
    } tdh_pend_t;
endpackage

// [core/tdh_core.sv]
/*
 Transmit and DMA descriptor handler: decodes descriptors, requests buffer
 gathers into the data FIFOs, queues finished frames and writes their
 completion indications back; also checks destination buffer descriptors.
 Assumes a fetcher that answers each request with one fetch_done pulse, a
 transmit/drain side that reports frames in order, and a memory writer for
 indications that acknowledges with ind_ack.
*/
// Notes on behaviour
// - Frames span up to sixteen buffers.
// - Decode flags, switch, mode, length, address.
// - Command path: single buffer into command FIFO.
// - Data FIFO chosen by source ring.
// - Leading header bytes pass through untouched.
// - Switch bit toggles port for remaining buffers.
// - Mode bit honoured in first descriptor only.
// - Single mode: one frame; normal mode prefetches.
// - Completion indication with single-buffer flag.
// - Transmit indication carries port error code.
// - Underrun sets underrun and abort, continues.
// - Parity abort sets parity error flag.
// - External abort: abort only, others zero.
// - DMA zero length means 8 Kbytes.
// - Last descriptor tag goes to destination.
// - DMA source indication with error flag.
// - DMA source port error codes.
// - Destination length field must be one-hot.
// - Discard flag aborts rest of DMA frame.
`timescale 1ns/1ps
module tdh_core
    import tdh_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Descriptor input
    input wire logic desc_valid,
    output logic desc_ready,
    input wire logic [63:0] desc_word,
    input wire logic [2:0] desc_ring,
    input wire logic [31:0] desc_entry_addr,
    input wire logic desc_via_cmd,
    input wire logic desc_is_dma,
    input wire logic desc_home_port,
    input wire logic fifo_space_ok,
    // Buffer gather request
    output logic fetch_req,
    output tdh_fetch_t fetch_transfer_tag,
    input wire logic fetch_done,
    input wire logic [2:0] fetch_err,
    // Frame completion from transmit or drain side
    input wire logic done_valid,
    input wire tdh_done_t done_status,
    output logic [11:0] dma_tag,
    // Destination descriptor check
    input wire logic dst_valid,
    input wire logic [63:0] dst_word,
    output logic [13:0] dst_len_bytes,
    output logic dst_len_bad,
    output logic dma_discard,
    // Indication write-back
    output logic ind_valid,
    output logic [31:0] ind_addr,
    output logic [63:0] ind_word,
    input wire logic ind_ack
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        tdh_state_t st;
        logic enable;
        logic [4:0] buf_cnt;
        logic cur_port;
        logic cur_last;
        logic frame_single;
        logic frame_mode;
        logic frame_dma;
        logic [2:0] frame_err;
        logic [11:0] frame_tag;
        logic [31:0] frame_addr;
        tdh_fetch_t fetch;
        tdh_pend_t [TDH_PEND_DEPTH-1:0] pend;
        logic [1:0] wr_ptr;
        logic [1:0] rd_ptr;
        logic [2:0] pend_cnt;
        logic done_hold;
        tdh_done_t done;
        logic discard_seen;
        logic [31:0] ind_addr;
        logic [63:0] ind_word;
        logic [15:0] frames;
        logic [31:0] last_ind;
        logic [31:0] rdata;
        logic [13:0] dst_len;
        logic dst_bad;
        logic discard;
    } tdh_core_state_t;

    tdh_core_state_t s_q;
    tdh_core_state_t s_d;

    function automatic logic perr_is_parity(input logic [2:0] code);
        perr_is_parity = (code == TDH_PERR_FIFO_PARITY) || (code == TDH_PERR_IM_PARITY)
            || (code == TDH_PERR_IM_LOCAL_PARITY);
    endfunction

    // ------------------------------------------------------------------
    // Descriptor decode
    // ------------------------------------------------------------------
    logic new_frame;
    logic d_first;
    logic d_last;
    logic d_mode;
    logic [12:0] d_len_raw;
    logic [13:0] d_len;
    logic d_port;
    logic blocked;
    tdh_pend_t head;
    logic [7:0] dst_field;

    always_comb
    begin
        head = s_q.pend[s_q.rd_ptr];
        new_frame = (s_q.buf_cnt == 5'h00);
        // The command path can only carry a one-buffer frame, so force both flags.
        d_first = desc_word[TDH_BIT_FIRST] || desc_via_cmd;
        d_last = desc_word[TDH_BIT_LAST] || desc_via_cmd
            || (s_q.buf_cnt == TDH_MAX_BUFS - 5'h01);
        d_mode = desc_word[TDH_BIT_MODE];
        d_len_raw = desc_word[TDH_LEN_HI:TDH_LEN_LO];
        // Transmit lengths are never zero; a zero DMA length is a full 8K buffer.
        d_len = (desc_is_dma && d_len_raw == 13'h0000) ? TDH_DMA_ZERO_LEN
            : {1'b0, d_len_raw};
        d_port = (new_frame ? desc_home_port : s_q.cur_port)
            ^ desc_word[TDH_BIT_SWITCH];
        blocked = 1'b0;
        if (new_frame)
        begin
            if (s_q.pend_cnt == TDH_PEND_FULL)
            begin
                blocked = 1'b1;
            end
            else if (s_q.pend_cnt != 3'h0 && (d_mode || head.mode))
            begin
                blocked = 1'b1;
            end
            else if (!d_mode && !fifo_space_ok)
            begin
                blocked = 1'b1;
            end
        end
        dst_field = dst_word[TDH_DST_LEN_HI:TDH_DST_LEN_LO];
    end

    assign desc_ready = (s_q.st == TDH_IDLE) && s_q.enable && !s_q.done_hold && !blocked;
    assign fetch_req = (s_q.st == TDH_FETCH);
    assign ind_valid = (s_q.st == TDH_IND);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic t_un;
    logic t_pe;
    logic t_ab;
    logic [2:0] t_per;
    logic [63:0] t_word;

    always_comb
    begin
        s_d = s_q;
        s_d.discard = 1'b0;
        t_un = 1'b0;
        t_pe = 1'b0;
        t_ab = 1'b0;
        t_per = TDH_PERR_NONE;
        t_word = 64'h0;

        if (reg_wr && reg_addr == TDH_REG_CTRL)
        begin
            s_d.enable = reg_wdata[TDH_CTRL_ENABLE];
        end

        s_d.rdata = 32'h0;
        if (reg_rd)
        begin
            case (reg_addr)
                TDH_REG_CTRL: s_d.rdata = {31'h0, s_q.enable};
                TDH_REG_STATUS: s_d.rdata = {20'h0, s_q.done_hold, s_q.cur_port,
                    s_q.buf_cnt, s_q.pend_cnt, s_q.st};
                TDH_REG_FRAMES: s_d.rdata = {16'h0, s_q.frames};
                TDH_REG_LAST_IND: s_d.rdata = s_q.last_ind;
                default: s_d.rdata = 32'h0;
            endcase
        end

        // Destination descriptor check and discard request.
        if (dst_valid)
        begin
            s_d.dst_bad = !$onehot(dst_field);
            s_d.dst_len = 14'h0000;
            for (int i = 0; i < 8; i++)
            begin
                if (dst_field == 8'(1 << i))
                begin
                    s_d.dst_len = 14'(TDH_DST_MIN_LEN << i);
                end
            end
            if (dst_word[TDH_DST_DISCARD])
            begin
                s_d.discard = 1'b1;
                s_d.discard_seen = 1'b1;
            end
        end

        case (s_q.st)
            TDH_IDLE:
            begin
                if (s_q.done_hold && s_q.pend_cnt != 3'h0)
                begin
                    if (head.dma)
                    begin
                        if (head.perr != TDH_PERR_NONE)
                        begin
                            t_per = head.perr;
                        end
                        else if (s_q.discard_seen || s_q.done.ext_abort)
                        begin
                            t_per = TDH_PERR_DST_ABORT;
                        end
                        else
                        begin
                            t_per = s_q.done.dst_perr;
                        end
                        t_ab = (t_per != TDH_PERR_NONE);
                        t_word[TDH_IND_TAG_HI:0] = head.tag;
                    end
                    else
                    begin
                        // A named cause masks the external abort, which then reads bare.
                        t_un = s_q.done.underrun;
                        t_per = head.perr;
                        t_pe = s_q.done.parity || perr_is_parity(head.perr);
                        t_ab = t_un || t_pe || (t_per != TDH_PERR_NONE)
                            || s_q.done.ext_abort;
                    end
                    t_word[TDH_IND_SINGLE] = head.single;
                    t_word[TDH_IND_PERR_HI:TDH_IND_PERR_LO] = t_per;
                    t_word[TDH_IND_ABORT] = t_ab;
                    t_word[TDH_IND_UNDERRUN] = t_un;
                    t_word[TDH_IND_PARITY] = t_pe;
                    s_d.ind_word = t_word;
                    s_d.ind_addr = head.addr;
                    s_d.done_hold = 1'b0;
                    s_d.st = TDH_IND;
                end
                else if (desc_valid && desc_ready)
                begin
                    if (new_frame)
                    begin
                        s_d.frame_mode = d_mode;
                        s_d.frame_dma = desc_is_dma;
                        s_d.frame_err = TDH_PERR_NONE;
                        s_d.frame_single = d_last;
                    end
                    s_d.cur_port = d_port;
                    s_d.cur_last = d_last;
                    s_d.frame_tag = desc_word[TDH_TAG_HI:TDH_TAG_LO];
                    s_d.frame_addr = desc_entry_addr;
                    // Address is passed whole; the fetcher copes with any alignment.
                    s_d.fetch.addr = desc_word[31:0];
                    s_d.fetch.len = d_len;
                    s_d.fetch.port = d_port;
                    s_d.fetch.fifo_sel = desc_ring;
                    s_d.fetch.cmd_fifo = desc_via_cmd;
                    s_d.st = TDH_FETCH;
                end
            end
            TDH_FETCH:
            begin
                if (fetch_done)
                begin
                    if (fetch_err != TDH_PERR_NONE && s_q.frame_err == TDH_PERR_NONE)
                    begin
                        s_d.frame_err = fetch_err;
                    end
                    if (s_q.cur_last)
                    begin
                        s_d.pend[s_q.wr_ptr] = '{addr: s_q.frame_addr,
                            single: s_q.frame_single, mode: s_q.frame_mode,
                            dma: s_q.frame_dma, perr: s_d.frame_err,
                            tag: s_q.frame_tag};
                        s_d.wr_ptr = s_q.wr_ptr + 2'h1;
                        s_d.pend_cnt = s_q.pend_cnt + 3'h1;
                        s_d.buf_cnt = 5'h00;
                    end
                    else
                    begin
                        s_d.buf_cnt = s_q.buf_cnt + 5'h01;
                    end
                    s_d.st = TDH_IDLE;
                end
            end
            TDH_IND:
            begin
                if (ind_ack)
                begin
                    s_d.rd_ptr = s_q.rd_ptr + 2'h1;
                    s_d.pend_cnt = s_q.pend_cnt - 3'h1;
                    s_d.frames = s_q.frames + 16'h0001;
                    s_d.last_ind = s_q.ind_word[63:32];
                    // A discard arriving in the pop cycle belongs to the next frame.
                    if (head.dma && !s_d.discard)
                    begin
                        s_d.discard_seen = 1'b0;
                    end
                    s_d.st = TDH_IDLE;
                end
            end
            default:
            begin
                s_d.st = TDH_IDLE;
            end
        endcase

        // A completion arriving as the previous one is consumed must survive.
        if (done_valid)
        begin
            s_d.done_hold = 1'b1;
            s_d.done = done_status;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_q <= '0;
            s_q.enable <= TDH_CTRL_ENABLE_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Header bytes travel inside the buffer data and are never looked at here.
    assign fetch_transfer_tag = s_q.fetch;
    assign reg_rdata = s_q.rdata;
    assign ind_addr = s_q.ind_addr;
    assign ind_word = s_q.ind_word;
    assign dma_tag = s_q.ind_word[TDH_IND_TAG_HI:0];
    assign dst_len_bytes = s_q.dst_len;
    assign dst_len_bad = s_q.dst_bad;
    assign dma_discard = s_q.discard;

endmodule // tdh_core

// [sim/tdh_core_props.sv]
/*
 Port assertions for tdh_core.
 Assumes one clock domain; bound to every tdh_core instance.
*/
`timescale 1ns/1ps
module tdh_core_props
    import tdh_pkg::*;
(
    // Clock and reset
    input logic core_clk,
    input logic reset_n,
    // Descriptor and fetch
    input logic desc_valid,
    input logic desc_ready,
    input logic [63:0] desc_word,
    input logic [2:0] desc_ring,
    input logic desc_via_cmd,
    input logic desc_is_dma,
    input logic desc_home_port,
    input logic fetch_req,
    input tdh_fetch_t fetch_transfer_tag,
    input logic fetch_done,
    // Destination and indication
    input logic dst_valid,
    input logic [63:0] dst_word,
    input logic [13:0] dst_len_bytes,
    input logic dst_len_bad,
    input logic dma_discard,
    input logic [11:0] dma_tag,
    input logic ind_valid,
    input logic [31:0] ind_addr,
    input logic [63:0] ind_word,
    input logic ind_ack
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    sequence taken_s;
        desc_valid && desc_ready;
    endsequence
    sequence first_s;
        taken_s ##0 desc_word[TDH_BIT_FIRST];
    endsequence
    tx_fetch_a: assert property (taken_s ##0 !desc_is_dma |=> fetch_req
        && fetch_transfer_tag.addr == $past(desc_word[31:0])
        && fetch_transfer_tag.len == {1'b0, $past(desc_word[44:32])})
        else $error("fetch fields wrong");
    dma_len_a: assert property (taken_s ##0 desc_is_dma && desc_word[44:32] == 13'h0
        |=> fetch_transfer_tag.len == TDH_DMA_ZERO_LEN)
        else $error("zero dma length not 8k");
    fifo_sel_a: assert property (taken_s |=> fetch_transfer_tag.fifo_sel == $past(desc_ring)
        && fetch_transfer_tag.cmd_fifo == $past(desc_via_cmd))
        else $error("fifo selection wrong");
    first_port_a: assert property (first_s |=> fetch_transfer_tag.port ==
        ($past(desc_home_port) ^ $past(desc_word[TDH_BIT_SWITCH])))
        else $error("first port wrong");
    fetch_hold_a: assert property (fetch_req && !fetch_done |-> !desc_ready
        ##1 (fetch_req && $stable(fetch_transfer_tag)))
        else $error("fetch request not held");
    dst_len_a: assert property (dst_valid && $onehot(dst_word[39:32])
        |=> !dst_len_bad && dst_len_bytes == {$past(dst_word[39:32]), 6'h0})
        else $error("length decode wrong");
    dst_bad_a: assert property (dst_valid && !$onehot(dst_word[39:32]) |=> dst_len_bad)
        else $error("bad length not flagged");
    discard_pulse_a: assert property (dst_valid && dst_word[TDH_DST_DISCARD]
        |=> dma_discard ##1 !dma_discard)
        else $error("discard pulse wrong");
    ind_hold_a: assert property (ind_valid && !ind_ack |=> ind_valid
        && $stable(ind_word) && $stable(ind_addr))
        else $error("indication not held");
    tag_copy_a: assert property (ind_valid && ind_ack |=> dma_tag == $past(ind_word[11:0]))
        else $error("tag output wrong");
endmodule // tdh_core_props

bind tdh_core tdh_core_props i_props (.core_clk, .reset_n, .desc_valid, .desc_ready,
    .desc_word, .desc_ring, .desc_via_cmd, .desc_is_dma, .desc_home_port, .fetch_req,
    .fetch_transfer_tag, .fetch_done, .dst_valid, .dst_word, .dst_len_bytes, .dst_len_bad,
    .dma_discard, .dma_tag, .ind_valid, .ind_addr, .ind_word, .ind_ack);

// [sim/tdh_far_model.sv]
/*
 Far-side model: buffer fetcher and indication memory writer.
 Assumes fetch_req and ind_valid stay high until answered.
*/
`timescale 1ns/1ps
module tdh_far_model
(
    // Clock and reset
    input logic core_clk,
    input logic reset_n,
    // Bench control
    input logic [3:0] lat,
    input logic [2:0] err_code,
    // Fetch and write-back
    input logic fetch_req,
    output logic fetch_done,
    output logic [2:0] fetch_err,
    input logic ind_valid,
    output logic ind_ack
);
    logic [3:0] fcnt_q, icnt_q;
    // The code only means something beside fetch_done; elsewhere it is inverted.
    assign fetch_err = fetch_done ? err_code : ~err_code;
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            fcnt_q <= 4'h0;
            icnt_q <= 4'h0;
            fetch_done <= 1'b0;
            ind_ack <= 1'b0;
        end
        else
        begin
            fcnt_q <= (fetch_req && !fetch_done) ? fcnt_q + 4'h1 : 4'h0;
            fetch_done <= fetch_req && !fetch_done && fcnt_q == lat;
            icnt_q <= (ind_valid && !ind_ack) ? icnt_q + 4'h1 : 4'h0;
            ind_ack <= ind_valid && !ind_ack && icnt_q == lat;
        end
    end
endmodule // tdh_far_model

// [sim/tdh_core_test.sv]
/*
 Bench for tdh_core: registers, frames, errors, DMA and destination checks.
 Assumes the far-side model answers fetches and indication writes.
*/
`timescale 1ns/1ps
module tdh_core_test
    import tdh_pkg::*;
;
    logic core_clk = 1'b0, reset_n = 1'b0;
    logic reg_wr = 1'b0, reg_rd = 1'b0, desc_valid = 1'b0, desc_via_cmd = 1'b0;
    logic desc_is_dma = 1'b0, desc_home_port = 1'b0, fifo_space_ok = 1'b1;
    logic done_valid = 1'b0, dst_valid = 1'b0;
    logic desc_ready, fetch_req, fetch_done, dst_len_bad, dma_discard, ind_valid, ind_ack;
    logic [3:0] reg_addr = 4'h0, lat = 4'h5;
    logic [31:0] reg_wdata = 32'h0, desc_entry_addr = 32'h0, reg_rdata, ind_addr, ia, r;
    logic [63:0] desc_word = 64'h0, dst_word = 64'h0, ind_word, iw;
    logic [2:0] desc_ring = 3'h0, err_code = 3'h0, fetch_err;
    tdh_fetch_t fetch_transfer_tag, fi;
    tdh_done_t done_status = '0;
    logic [11:0] dma_tag;
    logic [13:0] dst_len_bytes;
    logic [2:0] codes [6] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
    logic [2:0] dexp [4] = '{3'h0, 3'h1, 3'h2, 3'h7};
    int num_errors = 0, compares = 0;

    always #50 core_clk = ~core_clk;

    tdh_core i_dut (.*);
    tdh_far_model i_far (.*);

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task final_report();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Selector 0 waits on fetch_req, 1 on ind_valid, 2 on desc_ready.
    task wait_for(input int sel, input logic lvl);
        int n;
        n = 0;
        @(negedge core_clk);
        while ((sel == 0 ? fetch_req : sel == 1 ? ind_valid : desc_ready) !== lvl)
        begin
            n++;
            if (n > 50)
            begin
                chk(!lvl, lvl);
                final_report();
            end
            @(negedge core_clk);
        end
    endtask
    task rd(input logic [3:0] a);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        r = reg_rdata;
    endtask
    task wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    function automatic logic [63:0] d(input logic f, input logic l, input logic sw,
        input logic m, input logic [12:0] len, input logic [31:0] a);
        return {1'b1, 1'b0, f, l, 12'h0, 1'b0, sw, m, len, a};
    endfunction
    task send(input logic [63:0] w, input logic [2:0] ring, input logic [31:0] ent,
        input logic dma, input logic port, input logic [2:0] e);
        @(posedge core_clk);
        desc_valid <= 1'b1;
        desc_word <= w;
        desc_ring <= ring;
        desc_entry_addr <= ent;
        desc_is_dma <= dma;
        desc_home_port <= port;
        err_code <= e;
        wait_for(2, 1'b1);
        @(posedge core_clk);
        desc_valid <= 1'b0;
        wait_for(0, 1'b1);
        fi = fetch_transfer_tag;
        wait_for(0, 1'b0);
    endtask
    task finish(input tdh_done_t st);
        @(posedge core_clk);
        done_valid <= 1'b1;
        done_status <= st;
        @(posedge core_clk);
        done_valid <= 1'b0;
        wait_for(1, 1'b1);
        iw = ind_word;
        ia = ind_addr;
        wait_for(1, 1'b0);
    endtask
    task dst(input logic [63:0] w);
        @(posedge core_clk);
        dst_valid <= 1'b1;
        dst_word <= w;
        @(posedge core_clk);
        dst_valid <= 1'b0;
        @(negedge core_clk);
    endtask
    task refused();
        @(posedge core_clk);
        desc_valid <= 1'b1;
        desc_word <= d(1, 1, 0, 0, 13'h4, 32'ha000);
        repeat (3) @(negedge core_clk);
        chk(desc_ready, 1'b0);
        @(posedge core_clk);
        desc_valid <= 1'b0;
    endtask

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial
    begin
        repeat (4) @(posedge core_clk);
        reset_n <= 1'b1;
        rd(TDH_REG_CTRL);
        chk({desc_ready, r}, 33'h0);
        wr(TDH_REG_CTRL, 32'h1);
        rd(TDH_REG_CTRL);
        chk(r, 32'h1);
        rd(4'h2);
        chk(r, 32'h0);
        $display("registers done");
        send(d(1, 1, 0, 0, 13'h5, 32'h1000_0003), 3'h3, 32'h100, 0, 0, 0);
        chk(fi, {32'h1000_0003, 14'h5, 1'b0, 3'h3, 1'b0});
        finish('0);
        chk(ia, 32'h100);
        chk({iw[61], iw[50:45]}, 7'h40);
        lat <= 4'h0;
        send(d(1, 0, 0, 0, 13'h3, 32'h2000), 3'h0, 32'h200, 0, 1, 0);
        chk(fi.port, 1'b1);
        send(d(0, 0, 1, 0, 13'h40, 32'h3001), 3'h0, 32'h208, 0, 1, 3'h2);
        chk(fi.port, 1'b0);
        send(d(0, 1, 0, 0, 13'h1fff, 32'h3100), 3'h0, 32'h210, 0, 1, 0);
        chk(fi.port, 1'b0);
        finish('0);
        chk({ia, iw[61], iw[50:45]}, {32'h210, 7'h15});
        for (int i = 0; i < 16; i++)
            send(d(i == 0, 0, 0, 0, 13'h8, 32'h4000), 3'h1, 32'h400 + 8 * i, 0, 0, 0);
        finish('0);
        chk(ia, 32'h478);
        $display("transmit frames done");
        foreach (codes[k])
        begin
            send(d(1, 1, 0, 0, 13'h10, 32'h5000), 3'h2, 32'h500, 0, 0, codes[k]);
            finish('0);
            chk(iw[50:47], {codes[k], 1'b1});
            chk(iw[45], codes[k] inside {3'h2, 3'h6, 3'h7});
        end
        for (int k = 0; k < 2; k++)
        begin
            send(d(1, 1, 0, 0, 13'h10, 32'h5000), 3'h2, 32'h580, 0, 0, 0);
            finish(k ? 6'h08 : 6'h20);
            chk(iw[50:45], k ? 6'h04 : 6'h06);
        end
        $display("transmit errors done");
        send(d(1, 0, 0, 0, 13'h0, 32'h6000) | 64'h0111_0000_0000_0000, 3'h4, 32'h600, 1, 0, 0);
        chk(fi.len, TDH_DMA_ZERO_LEN);
        send(d(0, 1, 0, 0, 13'h20, 32'h6100) | 64'h0abc_0000_0000_0000, 3'h4, 32'h608, 1, 0, 0);
        dst(64'h4000_0001_0000_0000);
        chk(dma_discard, 1'b1);
        finish('0);
        chk({dma_tag, iw[11:0]}, 24'habcabc);
        chk({iw[61], iw[50:47]}, 5'h09);
        for (int k = 0; k < 4; k++)
        begin
            send(d(1, 1, 0, 0, 13'h8, 32'h7000), 3'h5, 32'h700, 1, 0, k == 3 ? 3'h0 : dexp[k]);
            finish({3'h0, k == 3 ? 3'h7 : 3'h0});
            chk({iw[61], iw[50:47]}, {1'b1, dexp[k], dexp[k] != 3'h0});
        end
        for (int k = 0; k < 8; k++)
        begin
            dst({24'h0, 8'h1 << k, 32'h0});
            chk({dma_discard, dst_len_bad, dst_len_bytes}, {2'b0, 14'h40 << k});
        end
        dst({24'h0, 8'h3, 32'h0});
        chk(dst_len_bad, 1'b1);
        $display("dma done");
        desc_via_cmd <= 1'b1;
        send(d(1, 1, 0, 0, 13'h4, 32'h8000), 3'h6, 32'h800, 0, 0, 0);
        chk(fi.cmd_fifo, 1'b1);
        desc_via_cmd <= 1'b0;
        finish('0);
        send(d(1, 1, 0, 1, 13'h4, 32'h9000), 3'h0, 32'h900, 0, 0, 0);
        refused();
        finish('0);
        send(d(1, 0, 0, 0, 13'h4, 32'h9000), 3'h0, 32'h910, 0, 0, 0);
        send(d(0, 1, 0, 1, 13'h4, 32'h9100), 3'h0, 32'h918, 0, 0, 0);
        fifo_space_ok <= 1'b0;
        refused();
        fifo_space_ok <= 1'b1;
        send(d(1, 1, 0, 0, 13'h4, 32'h9200), 3'h0, 32'h920, 0, 0, 0);
        finish('0);
        chk(ia, 32'h918);
        finish('0);
        chk(ia, 32'h920);
        $display("command and modes done");
        final_report();
    end
endmodule // tdh_core_test
